// ===== core/adc_bus_if.sv
`timescale 1ns/100ps
// Purpose: parallel word bus and trigger pin between host and converter
// Assumes: one clock, host drives strobes
// Notes: trigger pin resolved from the two enables
interface adc_bus_if;
    logic        cs;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        trig_dev_o;
    logic        trig_dev_oe;
    logic        trig_host_o;
    logic        trig_host_oe;
    logic        trig;
    logic        irq;
    assign trig = trig_dev_oe ? trig_dev_o : (trig_host_oe ? trig_host_o : 1'b0);
    modport device (input cs, wr, addr, wdata, trig, output rdata, trig_dev_o,
                    trig_dev_oe, irq);
    modport host (input rdata, trig, irq, output cs, wr, addr, wdata, trig_host_o,
                  trig_host_oe);
endinterface

// ===== core/adc_ctrl_pkg.sv
// Purpose: shared constants for the converter control block and its host
// Assumes: 16-bit word bus, one clock pclk at 100 MHz
// Notes:
// Notes on behaviour
// [R01] acquisition lasts 9 or 2 plus 2D
// [R02] control bits 8-9 select instruction section
// [R03] section two: limit one, sign, edge
// [R04] section three: limit two, sign, edge
// [R05] watchdog compares one sample against both limits
// [R06] bit 9 picks above or below trigger
// [R07] control register sits at word address 1000
// [R08] run bit reads status, stop after instruction
// [R09] reset bit stops, clears pointer, fifo, flags
// [R10] reset clears after two clocks unless standby
// [R11] power-up reset; host waits reset bit zero
// [R12] short calibration 76 clocks, sets status 3
// [R13] full calibration 4944 clocks, sets status 4
// [R14] standby gates clocking, memory stays accessible
// [R15] standby exit equals reset, then exit interrupt; code sets status bit 7 but irq stays low
// [R16] mask bit: tag bits copy sign
// [R17] auto-zero before each conversion when set
// [R18] bit 7 sets trigger pin as output
// [R19] input trigger rising edge starts conversion
// [R20] host keeps test bit at zero
// [R21] diagnostic bit works only with test zero
// [R22] diagnostic codes 000 and 001 reroute inputs
// [R23] events set flags regardless of enables
// [R24] standby exit delay counted by parameter
package adc_ctrl_pkg;
    localparam int          ADDR_W         = 5;
    localparam int          DATA_W         = 16;
    localparam logic [4:0]  ADDR_INSTR     = 5'h00;
    localparam logic [4:0]  ADDR_CONTROL   = 5'h08;
    localparam logic [4:0]  ADDR_STATUS    = 5'h0a;
    localparam int          BIT_RUN        = 0;
    localparam int          BIT_RESET      = 1;
    localparam int          BIT_SHORT_CAL  = 2;
    localparam int          BIT_FULL_CAL   = 3;
    localparam int          BIT_STANDBY    = 4;
    localparam int          BIT_TAG_MASK   = 5;
    localparam int          BIT_AUTO_ZERO  = 6;
    localparam int          BIT_TRIG_OUT   = 7;
    localparam int          BIT_PTR_LO     = 8;
    localparam int          BIT_TEST       = 10;
    localparam int          BIT_DIAG       = 11;
    localparam int          IBIT_WATCHDOG  = 11;
    localparam int          IBIT_8BIT      = 10;
    localparam int          IBIT_ACQ_LO    = 12;
    localparam int          LBIT_SIGN      = 8;
    localparam int          LBIT_ABOVE     = 9;
    localparam int          STAT_WATCHDOG  = 0;
    localparam int          STAT_SHORT_CAL = 3;
    localparam int          STAT_FULL_CAL  = 4;
    localparam int          STAT_STBY_EXIT = 7;
    localparam logic [15:0] CONTROL_RESET  = 16'h0002;
    localparam int          ACQ_BASE_13    = 9;
    localparam int          ACQ_BASE_9     = 2;
    localparam int          CONV_CYCLES    = 8;
    localparam int          RESET_CYCLES   = 2;
    localparam int          SHORT_CAL_CYC  = 76;
    localparam int          FULL_CAL_CYC   = 4944;
    localparam int          STBY_EXIT_CYC  = 1000;
    localparam logic [2:0]  DIAG_REF_GND   = 3'h0;
    localparam logic [2:0]  DIAG_REF_PAIR  = 3'h1;
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          APB_CTRL_OFS   = 0;
    localparam int          APB_DATA_OFS   = 4;
    localparam int          APB_RESP_OFS   = 8;
    typedef enum logic [1:0] {SRC_NORMAL, SRC_REF_GND, SRC_REF_PAIR} input_route_t;
endpackage

// ===== core/adc_device.sv
// Added by the designer: the word-bus register port.
`timescale 1ns/100ps
// Purpose: control end of the converter: config, instruction memory, sequencer
// Assumes: bus strobes synchronous to pclk; trigger pin asynchronous
// Notes: analog path replaced by sample input; conversion timing nominal
module adc_device #(
    parameter int STBY_EXIT = adc_ctrl_pkg::STBY_EXIT_CYC,
    parameter int FULL_CAL  = adc_ctrl_pkg::FULL_CAL_CYC
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    adc_bus_if.device                        bus,
    input  wire logic [8:0]                  sample,
    output logic                             result_valid,
    output logic [15:0]                      result,
    output logic                             fifo_clear,
    output adc_ctrl_pkg::input_route_t       route,
    output logic [2:0]                       channel,
    output logic                             standby
);
    import adc_ctrl_pkg::*;
    typedef enum {S_IDLE, S_AZ, S_ACQ, S_CONV, S_CMP2, S_CAL} seq_state_t;
    initial begin
        if (STBY_EXIT < 1 || STBY_EXIT > 65535 || FULL_CAL < SHORT_CAL_CYC || FULL_CAL > 8191)
            $error("bad timing");
    end
    logic [15:0] control;
    logic [15:0] instr [0:7][0:2];
    logic [7:0]  flags;
    logic [2:0]  iptr;
    logic        running;
    logic [1:0]  reset_cnt;
    logic        reset_pulse;
    logic        stby_prev;
    logic [15:0] stby_cnt;
    logic        trig_s1, trig_s2, trig_s3;
    logic        cal_full;
    seq_state_t  state;
    logic        t_load, t_done;
    logic [12:0] t_count;
    logic        wr_ctrl, wr_instr;
    logic [1:0]  sect;
    logic [15:0] i0, l1, l2;
    logic        hit1, hit2, stop_req;
    assign wr_ctrl  = bus.cs && bus.wr && bus.addr == ADDR_CONTROL; // R07
    assign wr_instr = bus.cs && bus.wr && bus.addr[4:3] == ADDR_INSTR[4:3];
    assign sect     = control[BIT_PTR_LO +: 2]; // R02
    assign i0 = instr[iptr][0];
    assign l1 = instr[iptr][1];
    assign l2 = instr[iptr][2];
    assign standby = control[BIT_STANDBY];
    assign reset_pulse = control[BIT_RESET] || (stby_prev && !standby); // R15
    // sequencer frozen in standby; instruction memory still reachable
    // reset bit: self-clears after two clocks, held by standby
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control   <= CONTROL_RESET; // R11
            reset_cnt <= '0;
        end else begin
            if (wr_ctrl) begin
                control <= {bus.wdata[15:1], control[BIT_RUN]};
                // standby forces the reset bit high until standby is left
                if (bus.wdata[BIT_STANDBY]) control[BIT_RESET] <= 1'b1; // R10
                if (bus.wdata[BIT_RESET] || bus.wdata[BIT_STANDBY]) reset_cnt <= '0;
            end else if (control[BIT_RESET] && !standby) begin // R10
                reset_cnt <= reset_cnt + 1'b1;
                if (reset_cnt == 2'(RESET_CYCLES - 1)) control[BIT_RESET] <= 1'b0;
            end
            if (state == S_CAL && t_done) begin // R12 R13
                control[BIT_SHORT_CAL] <= 1'b0;
                control[BIT_FULL_CAL]  <= 1'b0;
            end
        end
    end
    always_ff @(posedge pclk) begin
        if (wr_instr && sect != 2'b11) begin // R14
            instr[bus.addr[2:0]][sect] <= bus.wdata;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stby_prev <= 1'b0;
            stby_cnt  <= '0;
        end else begin
            stby_prev <= standby;
            if (stby_prev && !standby) stby_cnt <= 16'(STBY_EXIT); // R24
            else if (stby_cnt != '0) stby_cnt <= stby_cnt - 1'b1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_s3 <= 1'b0;
        end else begin
            trig_s1 <= bus.trig;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
        end
    end
    // limit compare on sign-magnitude values
    function automatic logic crosses(input logic [8:0] s, input logic [15:0] lim);
        logic signed [9:0] a;
        logic signed [9:0] b;
        a = s[8] ? -$signed({2'b00, s[7:0]}) : $signed({2'b00, s[7:0]});
        b = lim[LBIT_SIGN] ? -$signed({2'b00, lim[7:0]}) : $signed({2'b00, lim[7:0]});
        crosses = lim[LBIT_ABOVE] ? (a > b) : (a < b); // R06
    endfunction
    assign hit1 = crosses(sample, l1); // R03
    assign hit2 = crosses(sample, l2); // R04
    assign stop_req = wr_ctrl && !bus.wdata[BIT_RUN];
    always_comb begin
        t_load  = 1'b0;
        t_count = '0;
        case (state)
            S_IDLE: begin
                if (!standby && (control[BIT_SHORT_CAL] || control[BIT_FULL_CAL])) begin
                    t_load  = 1'b1;
                    t_count = control[BIT_FULL_CAL] ? 13'(FULL_CAL) : 13'(SHORT_CAL_CYC);
                end else if (running && (control[BIT_TRIG_OUT] || (trig_s2 && !trig_s3))) begin // R19
                    t_load  = 1'b1;
                    t_count = control[BIT_AUTO_ZERO] ? 13'(SHORT_CAL_CYC) // R17
                            : 13'((i0[IBIT_WATCHDOG] || i0[IBIT_8BIT] ? ACQ_BASE_9
                            : ACQ_BASE_13) + 2 * i0[IBIT_ACQ_LO +: 4]); // R01
                end
            end
            S_AZ: if (t_done) begin
                t_load  = 1'b1;
                t_count = 13'((i0[IBIT_WATCHDOG] || i0[IBIT_8BIT] ? ACQ_BASE_9 : ACQ_BASE_13)
                          + 2 * i0[IBIT_ACQ_LO +: 4]);
            end
            S_ACQ: if (t_done) begin
                t_load  = 1'b1;
                t_count = 13'(CONV_CYCLES);
            end
            default: begin
                t_load  = 1'b0;
                t_count = '0;
            end
        endcase
    end
    phase_timer #(.WIDTH(13)) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (t_load),
        .count   (t_count),
        .busy    (),
        .done    (t_done)
    );
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state        <= S_IDLE;
            running      <= 1'b0;
            iptr         <= '0;
            flags        <= '0;
            result_valid <= 1'b0;
            result       <= '0;
            cal_full     <= 1'b0;
        end else if (reset_pulse) begin // R09
            state        <= S_IDLE;
            running      <= 1'b0;
            iptr         <= '0;
            flags        <= '0;
            result_valid <= 1'b0;
        end else if (!standby) begin
            result_valid <= 1'b0;
            if (wr_ctrl && bus.wdata[BIT_RUN]) running <= 1'b1; // R08
            // clear-on-read first, so an event in the same cycle still sets its flag
            if (bus.cs && !bus.wr && bus.addr == ADDR_STATUS) flags <= '0;
            if (stby_cnt == 16'h0001) flags[STAT_STBY_EXIT] <= 1'b1; // R15
            case (state)
                S_IDLE: if (t_load) begin
                    if (control[BIT_SHORT_CAL] || control[BIT_FULL_CAL]) begin
                        state    <= S_CAL;
                        cal_full <= control[BIT_FULL_CAL];
                    end else begin
                        state <= control[BIT_AUTO_ZERO] ? S_AZ : S_ACQ;
                    end
                end
                S_AZ:   if (t_done) state <= S_ACQ;
                S_ACQ:  if (t_done) state <= S_CONV;
                S_CONV: if (t_done) begin
                    if (i0[IBIT_WATCHDOG]) begin // R05
                        if (hit1) flags[STAT_WATCHDOG] <= 1'b1; // R23
                        state <= S_CMP2;
                    end else begin
                        result_valid <= 1'b1;
                        result <= {control[BIT_TAG_MASK] ? {3{sample[8]}} : iptr, // R16
                                   {5{sample[8]}}, sample[7:0]};
                        iptr   <= iptr + 1'b1;
                        state  <= S_IDLE;
                    end
                end
                S_CMP2: begin
                    if (hit2) flags[STAT_WATCHDOG] <= 1'b1;
                    iptr  <= iptr + 1'b1;
                    state <= S_IDLE;
                end
                S_CAL: if (t_done) begin
                    flags[cal_full ? STAT_FULL_CAL : STAT_SHORT_CAL] <= 1'b1;
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
            if (stop_req && state == S_IDLE) running <= 1'b0;
            else if (stop_req) running <= 1'b0;
        end
    end
    assign fifo_clear = reset_pulse;
    assign channel = i0[4:2];
    always_comb begin
        route = SRC_NORMAL;
        if (control[BIT_DIAG] && !control[BIT_TEST]) begin // R21 R22
            if (channel == DIAG_REF_GND) route = SRC_REF_GND;
            else if (channel == DIAG_REF_PAIR) route = SRC_REF_PAIR;
        end
    end
    always_comb begin
        case (bus.addr)
            ADDR_CONTROL: bus.rdata = {control[15:1], running}; // R08
            ADDR_STATUS:  bus.rdata = {5'h00, iptr, flags};
            default:      bus.rdata = (bus.addr[4:3] == 2'b00 && sect != 2'b11)
                                      ? instr[bus.addr[2:0]][sect] : 16'h0000;
        endcase
    end
    assign bus.trig_dev_oe = control[BIT_TRIG_OUT]; // R18
    assign bus.trig_dev_o  = (state == S_ACQ || state == S_CONV || state == S_CMP2);
    assign bus.irq = 1'b0;
endmodule

// ===== core/adc_host.sv
`timescale 1ns/100ps
// Purpose: host end: APB slave that relays word accesses to the converter
// Assumes: bus access completes in one cycle on the device side
// Notes: pready tied high, so every access ends in its first access cycle
module adc_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    adc_bus_if.host          bus
);
    import adc_ctrl_pkg::*;
    logic [31:0] cmd;
    logic [15:0] resp;
    logic        go;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd  <= '0;
            resp <= '0;
            go   <= 1'b0;
        end else begin
            go <= 1'b0;
            if (psel && penable && pwrite && paddr == 12'(APB_CTRL_OFS)) begin
                cmd <= {pwdata[31:16] & 16'h00ff, pwdata[15:0]};
                go  <= 1'b1;
            end
            if (psel && penable && pwrite && paddr == 12'(APB_DATA_OFS))
                cmd[15:0] <= pwdata[15:0];
            if (go && !cmd[21]) resp <= bus.rdata;
        end
    end
    // cmd: [15:0] data, [20:16] addr, [21] write, [22] trigger drive, [23] trigger level
    // test bit forced low; trigger level stands until the next command
    assign bus.cs    = go;
    assign bus.wr    = cmd[21];
    assign bus.addr  = cmd[20:16];
    assign bus.wdata = (cmd[20:16] == ADDR_CONTROL)
                       ? (cmd[15:0] & ~(16'h0001 << BIT_TEST)) : cmd[15:0]; // R20
    assign bus.trig_host_o  = cmd[23]; // R19
    assign bus.trig_host_oe = cmd[22];
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    always_comb begin
        case (paddr)
            12'(APB_CTRL_OFS): prdata = cmd;
            12'(APB_DATA_OFS): prdata = {16'h0000, cmd[15:0]};
            12'(APB_RESP_OFS): prdata = {16'h0000, resp};
            default:           prdata = 32'h0000_0000;
        endcase
    end
endmodule

// ===== core/phase_timer.sv
`timescale 1ns/100ps
// Purpose: loadable down counter that marks the last cycle of a phase
// Assumes: load has priority over counting
// Notes: done pulses when count reaches one
module phase_timer #(
    parameter int WIDTH = 13
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] count,
    output logic                  busy,
    output logic                  done
);
    logic [WIDTH-1:0] remain;
    initial begin
        if (WIDTH < 2) $error("phase_timer width too small");
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remain <= '0;
        end else if (load) begin
            remain <= count;
        end else if (remain != '0) begin
            remain <= remain - 1'b1;
        end
    end
    assign busy = (remain != '0);
    // done must not look at load: callers reload on done, which would loop
    assign done = (remain == WIDTH'(1));
endmodule

// ===== testbench/adc_sequencer_control_props.sv
// Purpose: link checks between host end and converter end
// Assumes: device read data is valid while cs is high
// Notes: helper ages saturate, so stale events never fire
`timescale 1ns/100ps
module adc_sequencer_control_props #(
    parameter int FULL_CAL = 100
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        cs,
    input wire logic        wr,
    input wire logic [4:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic        trig_dev_oe
);
    logic        cw;
    logic        rd;
    logic [12:0] age;
    logic [12:0] sc;
    logic [12:0] fc;
    logic [12:0] sage;
    logic        ran;
    logic        stby;
    logic        shv;
    logic [15:0] sh;
    function automatic logic [12:0] inc(input logic [12:0] x);
        return (x == 13'h1fff) ? x : x + 13'h1;
    endfunction
    assign cw = cs && wr && addr == 5'h08;
    assign rd = cs && !wr && addr == 5'h08;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age  <= '0;
            sc   <= '1;
            fc   <= '1;
            sage <= '1;
            ran  <= 1'b0;
            stby <= 1'b0;
            shv  <= 1'b0;
            sh   <= '0;
        end else begin
            age  <= (cw && wdata[1]) ? '0 : inc(age);
            sc   <= (cw && wdata[2]) ? '0 : inc(sc);
            fc   <= (cw && wdata[3]) ? '0 : inc(fc);
            sage <= (cw && wdata[4] != stby) ? '0 : inc(sage);
            if (cw) begin
                ran  <= wdata[0] && !wdata[1];
                stby <= wdata[4];
                shv  <= !(stby && !wdata[4]);
                sh   <= wdata;
            end
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_trig_dir: assert property (cw |=> trig_dev_oe == $past(wdata[7]))
        else $error("trigger direction differs from control bit");
    a_cfg_fields: assert property (rd && shv |-> rdata[11:5] == {sh[11], 1'b0, sh[9:5]})
        else $error("control fields read back wrong");
    a_rst_clear: assert property (rd && age >= 4 && !stby && sage >= 40 |-> !rdata[1])
        else $error("reset bit still set");
    a_rst_hold: assert property (rd && stby && sage >= 2 |-> rdata[1])
        else $error("reset bit not held in standby");
    a_stby_read: assert property (rd && stby && sage >= 2 |-> rdata[4])
        else $error("standby bit lost");
    a_run_stop: assert property (rd && !ran && sage >= 40 && age >= 4 |-> !rdata[0])
        else $error("run bit set while stopped");
    a_short_busy: assert property (rd && !ran && sc >= 1 && sc <= 60 |-> rdata[2])
        else $error("short calibration ended early");
    a_short_done: assert property (rd && sc >= 90 |-> !rdata[2])
        else $error("short calibration bit stuck");
    a_full_done: assert property (rd && fc >= FULL_CAL + 20 |-> !rdata[3])
        else $error("full calibration bit stuck");
endmodule

// ===== testbench/adc_sequencer_control_tb_top.sv
// Purpose: end to end bench, APB in, converter control out
// Assumes: host relays each word access through its command word
// Notes: full calibration and standby settle counts shortened
`timescale 1ns/100ps
module adc_sequencer_control_tb_top;
    import adc_ctrl_pkg::*;
    localparam int FCAL = 100;
    localparam int SEXIT = 20;
    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [11:0]  paddr = '0;
    logic [31:0]  pwdata = '0;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic [8:0]   sample = '0;
    logic         result_valid;
    logic [15:0]  result;
    input_route_t route;
    logic [2:0]   channel;
    logic         standby;
    logic         diag_chk = 1'b0;
    logic         diag_on = 1'b0;
    logic         fix = 1'b0;
    logic [15:0]  lfsr = 16'h0019;
    logic [15:0]  mem [3][8];
    logic [15:0]  r;
    logic [31:0]  q32;
    logic         fifo_clear;
    logic [15:0]  wd [3][4] = '{'{16'h0800, 16'h020a, 16'h02ff, 16'h8032},
                                '{16'h0800, 16'h020a, 16'h02ff, 16'h0005},
                                '{16'h0800, 16'h02ff, 16'h000a, 16'h8005}};
    int           errors = 0;
    int           checks_done = 0;
    adc_bus_if bus ();
    adc_host u_adc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(bus));
    adc_device #(.STBY_EXIT(SEXIT), .FULL_CAL(FCAL)) u_adc_device (.pclk(pclk),
        .presetn(presetn), .bus(bus), .sample(sample), .result_valid(result_valid),
        .result(result), .fifo_clear(fifo_clear), .route(route), .channel(channel),
        .standby(standby));
    adc_sequencer_control_props #(.FULL_CAL(FCAL)) u_props (.pclk(pclk), .presetn(presetn),
        .cs(bus.cs), .wr(bus.wr), .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata),
        .trig_dev_oe(bus.trig_dev_oe));
    always #5 pclk = ~pclk;
    function automatic logic [15:0] nxt(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [15:0] msk(input int s);
        return (s == 0) ? 16'hfc1c : 16'h03ff;
    endfunction
    function automatic input_route_t exp_route(input logic [2:0] c, input logic on);
        if (!on || c > 3'h1) return SRC_NORMAL;
        return (c == 3'h0) ? SRC_REF_GND : SRC_REF_PAIR;
    endfunction
    always @(posedge pclk) begin
        lfsr <= nxt(lfsr);
        if (!fix) sample <= lfsr[8:0];
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // slave answer time is not assumed; only the watchdog ends a stuck wait
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic dev_wr(input logic [4:0] a, input logic [15:0] d);
        logic [31:0] q;
        apb(1'b1, 12'h0, {10'h0, 1'b1, a, d}, q);
    endtask
    task automatic dev_rd(input logic [4:0] a, output logic [15:0] v);
        logic [31:0] q;
        apb(1'b1, 12'h0, {11'h0, a, 16'h0}, q);
        repeat (2) @(posedge pclk);
        apb(1'b0, 12'h8, 32'h0, q);
        v = q[15:0];
    endtask
    initial begin
        repeat (40000) @(posedge pclk);
        errors++;
        summarize();
    end
    always @(negedge pclk) if (diag_chk) check(16'(route), 16'(exp_route(channel, diag_on)));
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        r = 16'hffff;
        for (int i = 0; i < 20 && r[1] !== 1'b0; i++) dev_rd(ADDR_CONTROL, r);
        check(r, 16'h0000);
        for (int s = 0; s < 3; s++) begin
            dev_wr(ADDR_CONTROL, 16'(s << 8));
            for (int n = 0; n < 8; n++) begin
                mem[s][n] = lfsr & msk(s);
                dev_wr(5'(n), mem[s][n]);
            end
        end
        for (int s = 0; s < 4; s++) begin
            dev_wr(ADDR_CONTROL, 16'(s << 8));
            for (int n = 0; n < 8; n++) begin
                dev_rd(5'(n), r);
                check(r & msk(s), (s == 3) ? 16'h0 : mem[s][n]);
            end
        end
        for (int i = 0; i < 6; i++) begin
            r = (lfsr & 16'h0be0) | ((i == 0) ? 16'h0400 : 16'h0);
            dev_wr(ADDR_CONTROL, r);
            repeat (2) @(posedge pclk);
            check(16'(bus.trig_dev_oe), 16'(r[7]));
            dev_rd(ADDR_CONTROL, mem[0][0]);
            check(mem[0][0], r & 16'hfbff);
        end
        apb(1'b0, 12'h100, 32'h0, q32);
        check(16'(pslverr), 16'h0);
        dev_wr(ADDR_CONTROL, 16'h0000);
        dev_rd(ADDR_STATUS, r);
        for (int k = 0; k < 2; k++) begin
            dev_wr(ADDR_CONTROL, k ? 16'h0008 : 16'h0004);
            dev_rd(ADDR_CONTROL, r);
            check(r & 16'h000c, k ? 16'h0008 : 16'h0004);
            repeat (k ? FCAL + 20 : 90) @(posedge pclk);
            dev_rd(ADDR_CONTROL, r);
            check(r & 16'h000c, 16'h0000);
            dev_rd(ADDR_STATUS, r);
            check(r & 16'h0018, k ? 16'h0010 : 16'h0008);
        end
        for (int n = 0; n < 8; n++) dev_wr(5'(n), 16'(n << 2));
        for (int m = 0; m < 2; m++) begin
            dev_wr(ADDR_CONTROL, 16'h0002);
            repeat (4) @(posedge pclk);
            dev_wr(ADDR_CONTROL, m ? 16'h08a1 : 16'h0001);
            // trigger pin as input: host raises it once to start one conversion
            if (m == 0) apb(1'b1, 12'h0, {8'h00, 2'b11, 1'b0, ADDR_STATUS, 16'h0000}, q32);
            diag_on = m[0];
            do @(negedge pclk); while (result_valid !== 1'b1);
            check(16'(result[15:13]), m ? 16'({3{result[12]}}) : 16'h0);
            diag_chk = 1'b1;
            repeat (100) @(posedge pclk);
            dev_rd(ADDR_CONTROL, r);
            check(16'(r[0]), 16'h1);
            diag_chk = 1'b0;
            dev_wr(ADDR_CONTROL, m ? 16'h0002 : 16'h0000);
            repeat (4) @(posedge pclk);
            dev_rd(ADDR_CONTROL, r);
            check(16'(r[0]), 16'h0);
        end
        dev_rd(ADDR_STATUS, r);
        check(16'(r[10:8]), 16'h0);
        fix = 1'b1;
        for (int c = 0; c < 3; c++) begin
            sample <= wd[c][3][8:0];
            for (int s = 0; s < 3; s++) begin
                dev_wr(ADDR_CONTROL, 16'(s << 8));
                for (int n = 0; n < 8; n++) dev_wr(5'(n), wd[c][s]);
            end
            dev_rd(ADDR_STATUS, r);
            dev_wr(ADDR_CONTROL, 16'h0081);
            repeat (100) @(posedge pclk);
            dev_wr(ADDR_CONTROL, 16'h0000);
            dev_rd(ADDR_STATUS, r);
            check(16'(r[0]), 16'(wd[c][3][15]));
        end
        fix = 1'b0;
        dev_wr(ADDR_CONTROL, 16'h0010);
        repeat (3) @(posedge pclk);
        check(16'(standby), 16'h1);
        check(16'(fifo_clear), 16'h1);
        dev_wr(5'h0, 16'h5c14);
        dev_rd(5'h0, r);
        check(r & 16'hfc1c, 16'h5c14);
        dev_rd(ADDR_CONTROL, r);
        check(r & 16'h0012, 16'h0012);
        dev_wr(ADDR_CONTROL, 16'h0000);
        dev_rd(ADDR_STATUS, r);
        check(16'(r[7]), 16'h0);
        repeat (SEXIT + 20) @(posedge pclk);
        dev_rd(ADDR_STATUS, r);
        check(16'(r[7]), 16'h1);
        check(16'(standby), 16'h0);
        check(16'(fifo_clear), 16'h0);
        summarize();
    end
endmodule
